// [dipc_pkg.sv]
// Purpose: Shared constants and types for the interrupt and low-power controller
// Assumes: One clock; clk_i is the input clock, one instruction per clock in run mode
// Notes:   Source index 0 is the highest priority, 11 the lowest
package dipc_pkg;

  localparam int          DIPC_NSRC       = 12;
  localparam int          DIPC_NMASK      = 10;
  localparam int          DIPC_STK_DEPTH  = 12;
  localparam int          DIPC_VEC_W      = 16;

  // Source indices in descending priority
  localparam logic [3:0]  DIPC_SRC_RESET  = 4'h0;
  localparam logic [3:0]  DIPC_SRC_PWD    = 4'h1;
  localparam logic [3:0]  DIPC_SRC_EXT_REQUEST_TWO   = 4'h2;
  localparam logic [3:0]  DIPC_SRC_EDGE_REQUEST_PIN   = 4'h7;
  localparam logic [3:0]  DIPC_SRC_B_TX   = 4'h9;
  localparam logic [3:0]  DIPC_SRC_B_RX   = 4'ha;
  localparam logic [3:0]  DIPC_LVL_NONE   = 4'hf;

  // Vector per source index
  localparam logic [11:0][15:0] DIPC_VEC_TABLE = {
    16'h0028, 16'h0024, 16'h0020, 16'h001c, 16'h0018, 16'h0014,
    16'h0010, 16'h000c, 16'h0008, 16'h0004, 16'h002c, 16'h0000};

  // Control word fields
  localparam int          DIPC_CTL_NEST   = 3;
  localparam logic [2:0]  DIPC_CTL_RST    = 3'h0;

  // Level-only sources and sense-selectable sources
  localparam logic [11:0] DIPC_LEVEL_FIX  = 12'h018;
  localparam logic [11:0] DIPC_LEVEL_PROG = 12'h604;

  // Slow idle divisor base (16 << code)
  localparam logic [7:0]  DIPC_DIV_BASE   = 8'h10;

  // Recovery counts in input clock cycles
  localparam int          DIPC_REC_RUN    = 200;
  localparam int          DIPC_REC_OSC    = 4096;

  typedef enum logic [1:0] {DIPC_RUN, DIPC_IDLE, DIPC_PD, DIPC_RECOVER} dipc_mode_t;

  typedef struct packed {
    logic       ext_request_two;
    logic       ext_request_one;
    logic       ext_request_zero;
    logic       level_request_one;
    logic       level_request_zero;
    logic       edge_request_pin;
    logic       sp_a_tx;
    logic       sp_a_rx;
    logic       sp_b_tx;
    logic       sp_b_rx;
    logic       byte_dma;
    logic       timer;
  } dipc_src_t;

endpackage : dipc_pkg

// [dipc_ctrl.sv]
// Purpose: Interrupt prioritising, vectoring, masking and low-power mode control
// Assumes: Request inputs active high and synchronous; peripherals pulse or hold requests
// Notes:   The sequencer takes a vector with irq_ack_i and returns with rti_i
//
// What this block does
// - Eleven sources plus reset, each fixed vector
// - Reset 0000 top, power-down 002C, timer 0028 last
// - Request two, level one, level zero, edge vectors
// - Serial ports and byte DMA vectors
// - Mask gates requests; highest unmasked wins
// - Power-down and reset ignore the mask
// - Request pins two, one, zero sense selectable
// - Edge pin always edge, forceable; level pins level
// - Nesting control: preempt or sequential
// - Mask write blocks interrupts in its cycle and the next
// - Write-only force and clear port
// - Status pushed on entry, twelve-level stack
// - Global enable gates all but reset, including power-down
// - Global enable set after reset
// - Idle waits for unmasked interrupt, then resumes
// - Slow idle divides clock by 16 to 128
// - Slow idle exit within divisor cycles
// - Power-down exit after 200 clocks, oscillator running
// - Oscillator off: wait 4096 clocks on exit
// - Power-down requested by pin or force bit
// - Reset ends power-down; acknowledge shows entry
// - Power-down edge interrupt; context restart choice
`timescale 1ns/1ps
module dipc_ctrl
  import dipc_pkg::*;
#(
  parameter int REC_RUN = DIPC_REC_RUN,
  parameter int REC_OSC = DIPC_REC_OSC
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  // Request sources
  input  wire dipc_src_t             src_i,
  input  wire logic                  sp_b_irq_mode_i,
  input  wire logic                  power_down_pin_i,
  // Control writes from the sequencer
  input  wire logic                  mask_wr_i,
  input  wire logic [DIPC_NMASK-1:0] mask_data_i,
  input  wire logic                  control_wr_i,
  input  wire logic [3:0]            control_data_i,
  input  wire logic                  force_clear_wr_i,
  input  wire logic [DIPC_NSRC-1:0]  force_data_i,
  input  wire logic [DIPC_NSRC-1:0]  clear_data_i,
  input  wire logic                  irq_enable_i,
  input  wire logic                  irq_disable_i,
  // Low-power commands
  input  wire logic                  idle_i,
  input  wire logic                  idle_slow_i,
  input  wire logic [1:0]            idle_div_i,
  input  wire logic                  pd_enter_i,
  input  wire logic                  osc_off_i,
  input  wire logic                  power_up_context_flag_i,
  // Sequencer handshake
  input  wire logic                  irq_ack_i,
  input  wire logic                  rti_i,
  output logic                       irq_req_o,
  output logic [DIPC_VEC_W-1:0]      vector_o,
  // Status
  output logic [3:0]                 stack_depth_o,
  output logic                       stack_ovf_o,
  output logic [DIPC_NMASK-1:0]      interrupt_mask_reg_o,
  output logic                       run_o,
  output logic                       clk_en_o,
  output logic                       idle_o,
  output logic                       pd_ack_o
);

  typedef struct packed {
    dipc_mode_t                   mode;
    logic [DIPC_NMASK-1:0]        mask;
    logic                         nest;
    logic [2:0]                   sense;
    logic                         gie;
    logic                         blk;
    logic [DIPC_NSRC-1:0]         latch;
    logic [DIPC_NSRC-1:0]         prev;
    logic [DIPC_STK_DEPTH-1:0][3:0] stk;
    logic [3:0]                   sp;
    logic                         ovf;
    logic                         irq;
    logic [3:0]                   sel;
    logic [DIPC_VEC_W-1:0]        vec;
    logic                         slow;
    logic [7:0]                   div_n;
    logic [7:0]                   div_cnt;
    logic                         clk_en;
    logic [12:0]                  rec_cnt;
    logic                         pd_pin_q;
    logic                         run;
    logic                         idle;
    logic                         pdack;
  } dipc_state_t;

  dipc_state_t s_q, s_d;

  logic [DIPC_NSRC-1:0] raw;
  logic [DIPC_NSRC-1:0] lvl;
  logic [DIPC_NSRC-1:0] pend;
  logic [DIPC_NSRC-1:0] elig;
  logic [3:0]           top;
  logic [3:0]           pick;
  logic                 any;
  logic                 tick;

  // Lowest set index wins
  function automatic logic [3:0] dipc_first(input logic [DIPC_NSRC-1:0] v);
    logic [3:0] r;
    r = DIPC_LVL_NONE;
    for (int i = DIPC_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  always_comb begin
    raw = {src_i.timer,
           sp_b_irq_mode_i ? src_i.ext_request_zero : src_i.sp_b_rx,
           sp_b_irq_mode_i ? src_i.ext_request_one  : src_i.sp_b_tx,
           src_i.byte_dma, src_i.edge_request_pin, src_i.sp_a_rx, src_i.sp_a_tx,
           src_i.level_request_zero, src_i.level_request_one, src_i.ext_request_two,
           power_down_pin_i, 1'b0};
    lvl = DIPC_LEVEL_FIX;
    lvl[DIPC_SRC_EXT_REQUEST_TWO] = ~s_q.sense[2];
    lvl[DIPC_SRC_B_TX] = sp_b_irq_mode_i & ~s_q.sense[1];
    lvl[DIPC_SRC_B_RX] = sp_b_irq_mode_i & ~s_q.sense[0];
    pend = s_q.latch | (raw & lvl);
    elig = pend & {s_q.mask, 2'b11};
    if (!s_q.gie || s_q.blk) begin
      elig[DIPC_NSRC-1:1] = '0;
    end
    top = (s_q.sp == 4'h0) ? DIPC_LVL_NONE : s_q.stk[s_q.sp - 4'h1];
    pick = dipc_first(elig);
    if (s_q.nest) begin
      any = (pick != DIPC_LVL_NONE) && (pick < top);
    end else begin
      any = (pick != DIPC_LVL_NONE) && (top == DIPC_LVL_NONE || pick == DIPC_SRC_RESET);
    end
    tick = (s_q.div_cnt == 8'h00);
  end

  always_comb begin
    s_d = s_q;
    s_d.prev = raw;
    s_d.pd_pin_q = power_down_pin_i;
    s_d.blk = mask_wr_i;
    if (mask_wr_i) begin
      s_d.mask = mask_data_i;
    end
    if (control_wr_i) begin
      s_d.nest = control_data_i[DIPC_CTL_NEST];
      s_d.sense = control_data_i[2:0];
    end
    if (irq_enable_i) begin
      s_d.gie = 1'b1;
    end else if (irq_disable_i) begin
      s_d.gie = 1'b0;
    end
    // Clear first, then sets so that a new event is kept; a power-down edge in power-down is dropped
    if (irq_ack_i && s_q.irq) begin
      s_d.latch[s_q.sel] = 1'b0;
    end
    if (force_clear_wr_i) begin
      s_d.latch = s_d.latch & ~clear_data_i;
      s_d.latch = s_d.latch | force_data_i;
    end
    s_d.latch = s_d.latch | (raw & ~s_q.prev & ~lvl);
    if (s_q.mode == DIPC_PD) begin
      s_d.latch[DIPC_SRC_PWD] = s_q.latch[DIPC_SRC_PWD];
    end
    // Status stack
    if (irq_ack_i && s_q.irq) begin
      if (s_q.sp == 4'(DIPC_STK_DEPTH)) begin
        s_d.ovf = 1'b1;
      end else begin
        s_d.stk[s_q.sp] = s_q.sel;
        s_d.sp = s_q.sp + 4'h1;
      end
    end else if (rti_i && s_q.sp != 4'h0) begin
      s_d.sp = s_q.sp - 4'h1;
    end
    // Divider for slow idle
    s_d.div_cnt = tick ? s_q.div_n - 8'h01 : s_q.div_cnt - 8'h01;
    s_d.clk_en = 1'b1;
    s_d.irq = 1'b0;
    case (s_q.mode)
      DIPC_RUN: begin
        s_d.irq = any && !(irq_ack_i && s_q.irq) && !mask_wr_i;
        s_d.sel = pick;
        s_d.vec = DIPC_VEC_TABLE[pick];
        if (pd_enter_i) begin
          s_d.mode = DIPC_PD;
          s_d.clk_en = 1'b0;
        end else if (idle_i) begin
          s_d.mode = DIPC_IDLE;
          s_d.slow = idle_slow_i;
          s_d.div_n = DIPC_DIV_BASE << idle_div_i;
          s_d.div_cnt = (DIPC_DIV_BASE << idle_div_i) - 8'h01;
          s_d.clk_en = !idle_slow_i;
        end
      end
      DIPC_IDLE: begin
        s_d.clk_en = !s_q.slow || tick;
        if (any && (!s_q.slow || tick)) begin
          s_d.mode = DIPC_RUN;
          s_d.slow = 1'b0;
          s_d.clk_en = 1'b1;
        end
      end
      DIPC_PD: begin
        s_d.clk_en = 1'b0;
        if (power_down_pin_i && !s_q.pd_pin_q) begin
          s_d.mode = DIPC_RECOVER;
          s_d.rec_cnt = osc_off_i ? 13'(REC_OSC - 1) : 13'(REC_RUN - 1);
        end
      end
      DIPC_RECOVER: begin
        s_d.clk_en = 1'b0;
        s_d.rec_cnt = s_q.rec_cnt - 13'h1;
        if (s_q.rec_cnt == 13'h0) begin
          s_d.mode = DIPC_RUN;
          s_d.clk_en = 1'b1;
          if (power_up_context_flag_i) begin
            s_d.latch[DIPC_SRC_RESET] = 1'b1;
            s_d.sp = 4'h0;
          end
        end
      end
      default: begin
        s_d.mode = DIPC_RUN;
      end
    endcase
    s_d.run   = (s_d.mode == DIPC_RUN);
    s_d.idle  = (s_d.mode == DIPC_IDLE);
    s_d.pdack = (s_d.mode == DIPC_PD);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.mode <= DIPC_RUN;
      s_q.run <= 1'b1;
      s_q.gie <= 1'b1;
      s_q.sense <= DIPC_CTL_RST;
      s_q.latch <= 12'h001;
      s_q.div_n <= DIPC_DIV_BASE;
      s_q.clk_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign irq_req_o            = s_q.irq;
  assign vector_o             = s_q.vec;
  assign stack_depth_o        = s_q.sp;
  assign stack_ovf_o          = s_q.ovf;
  assign interrupt_mask_reg_o = s_q.mask;
  assign run_o                = s_q.run;
  assign clk_en_o             = s_q.clk_en;
  assign idle_o               = s_q.idle;
  assign pd_ack_o             = s_q.pdack;

  a_reset_vector: assert property (@(posedge clk_i) $fell(sys_rst_i) |-> ##1 irq_req_o && vector_o == 16'h0000)
    else $error("reset vector not issued");
  a_mask_block: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $past(mask_wr_i) && s_q.mode == DIPC_RUN |=> !irq_req_o || vector_o == 16'h0000)
    else $error("interrupt taken in blocked cycle");
  a_gie_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !s_q.gie && !irq_enable_i |=> !irq_req_o || vector_o == 16'h0000)
    else $error("request while globally disabled");
  a_mask_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_req_o && s_q.sel > DIPC_SRC_PWD |-> s_q.mask[s_q.sel - 4'h2])
    else $error("masked source vectored");
  a_stack_push: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_ack_i && irq_req_o && stack_depth_o < 4'hc |=> stack_depth_o == $past(stack_depth_o) + 4'h1)
    else $error("stack did not push");
  a_recover_run: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_q.mode == DIPC_PD && $rose(power_down_pin_i) && !osc_off_i |=> ##REC_RUN run_o)
    else $error("recovery count wrong");
  a_pd_ack_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(pd_ack_o) |-> $past(pd_enter_i) && !clk_en_o)
    else $error("power-down acknowledge without entry");
  a_slow_wake: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    idle_o && any |-> ##[1:128] !idle_o)
    else $error("slow idle wake too late");
  a_edge_latch: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(src_i.edge_request_pin) && !force_clear_wr_i |=> s_q.latch[DIPC_SRC_EDGE_REQUEST_PIN])
    else $error("edge request not latched");
  a_irq_gap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mask_wr_i |=> !irq_req_o || vector_o == 16'h0000)
    else $error("interrupt raised on mask write");
  a_osc_load: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_q.mode == DIPC_PD && $rose(power_down_pin_i) && osc_off_i |=> s_q.rec_cnt == 13'(REC_OSC - 1))
    else $error("oscillator recovery count wrong");
  a_pd_clk_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pd_ack_o |-> !clk_en_o)
    else $error("clock enabled in power-down");

endmodule // dipc_ctrl

// [dipc_src_model.sv]
// Purpose: Far-side model of request pins and peripheral request lines
// Assumes: Bench commands reach the lines one clock later
// Notes:   Peripheral events are one-cycle pulses
`timescale 1ns/1ps
module dipc_src_model
  import dipc_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Bench commands
  input  wire dipc_src_t  pulse_i,
  input  wire logic [1:0] level_i,
  input  wire logic       pd_pin_i,
  // Lines to the controller
  output dipc_src_t       src_o,
  output logic            power_down_pin_o
);
  always_ff @(posedge clk_i) begin
    src_o                    <= pulse_i;    // Edge events last one cycle
    src_o.level_request_one  <= level_i[1]; // Level pins held while asked
    src_o.level_request_zero <= level_i[0];
    power_down_pin_o         <= pd_pin_i;   // Far side asks for power-down
  end
endmodule // dipc_src_model

// [tb_dsp_interrupt_and_low_power_control.sv]
// Purpose: Self-checking bench for the interrupt and low-power controller
// Assumes: Inputs change by non-blocking assignment at the rising edge
// Notes:   Recovery counts shortened to 4 and 8 cycles
`timescale 1ns/1ps
module tb_dsp_interrupt_and_low_power_control
  import dipc_pkg::*;
;
  localparam int RR = 4;
  localparam int RO = 8;
  logic                  clk_i, sys_rst_i, sp_b_irq_mode_i, power_down_pin_i, pd_cmd;
  logic                  idle_slow_i, osc_off_i, power_up_context_flag_i;
  logic                  irq_req_o, stack_ovf_o, run_o, clk_en_o, idle_o, pd_ack_o;
  logic                  mask_wr_i, control_wr_i, force_clear_wr_i, irq_enable_i, irq_disable_i;
  logic                  idle_i, pd_enter_i, irq_ack_i, rti_i;
  logic [8:0]            stb;
  logic [DIPC_NMASK-1:0] mask_data_i, interrupt_mask_reg_o;
  logic [3:0]            control_data_i, stack_depth_o;
  logic [DIPC_NSRC-1:0]  force_data_i, clear_data_i;
  logic [1:0]            idle_div_i, lvl;
  logic [DIPC_VEC_W-1:0] vector_o;
  dipc_src_t             src_i, pls;
  int                    bad_count, n_checks, cycles, seed, pend, msk, k;
  int                    vec_of [12] = '{16'h0000, 16'h002c, 16'h0004, 16'h0008, 16'h000c, 16'h0010,
                                         16'h0014, 16'h0018, 16'h001c, 16'h0020, 16'h0024, 16'h0028};
  assign {rti_i, irq_ack_i, pd_enter_i, idle_i, irq_disable_i, irq_enable_i, force_clear_wr_i, control_wr_i,
          mask_wr_i} = stb;
  dipc_ctrl #(.REC_RUN(RR), .REC_OSC(RO)) dipc_ctrl_inst (
    .clk_i, .sys_rst_i, .src_i, .sp_b_irq_mode_i, .power_down_pin_i, .mask_wr_i, .mask_data_i, .control_wr_i,
    .control_data_i, .force_clear_wr_i, .force_data_i, .clear_data_i, .irq_enable_i, .irq_disable_i, .idle_i,
    .idle_slow_i, .idle_div_i, .pd_enter_i, .osc_off_i, .power_up_context_flag_i, .irq_ack_i, .rti_i,
    .irq_req_o, .vector_o, .stack_depth_o, .stack_ovf_o, .interrupt_mask_reg_o, .run_o, .clk_en_o, .idle_o,
    .pd_ack_o);
  dipc_src_model dipc_src_model_inst (.clk_i, .pulse_i(pls), .level_i(lvl), .pd_pin_i(pd_cmd), .src_o(src_i),
                                      .power_down_pin_o(power_down_pin_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      bad_count++;
      results();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Strobe b for one edge with its data
  task automatic wr(input int b, input logic [11:0] d = 12'h000, input logic [11:0] c = 12'h000);
    @(posedge clk_i);
    stb[b]         <= 1'b1;
    mask_data_i    <= d[9:0];
    control_data_i <= d[3:0];
    force_data_i   <= d;
    clear_data_i   <= c;
    cyc(1);
    stb[b] <= 1'b0;
  endtask
  task automatic pulse(input logic [11:0] p);
    @(posedge clk_i);
    pls <= dipc_src_t'(p);
    @(posedge clk_i);
    pls <= '0;
  endtask
  task automatic take(input int i);
    logic [3:0] d0;
    k = 0;
    while (irq_req_o !== 1'b1 && k < 40) begin
      cyc(1);
      k++;
    end
    check("irq_req_o", {15'h0, irq_req_o}, 16'h0001);
    check("vector_o", vector_o, 16'(vec_of[i]));
    d0 = stack_depth_o;
    wr(7);
    check("depth", {12'h0, stack_depth_o}, {12'h0, d0 + 4'h1});
  endtask
  task automatic ret();
    logic [3:0] d0;
    d0 = stack_depth_o;
    check("irq_req_o", {15'h0, irq_req_o}, 16'h0000);
    wr(8);
    check("depth", {12'h0, stack_depth_o}, {12'h0, d0 - 4'h1});
  endtask
  // Model: highest unmasked pending source
  function automatic int pick(input int p, input int m);
    pick = -1;
    for (int i = 11; i >= 1; i--)
      if (p[i] && (i < 2 || m[i-2])) pick = i;
  endfunction
  task automatic drain();
    int i;
    i = pick(pend, msk);
    while (i >= 0) begin
      take(i);
      ret();
      pend[i] = 0;
      i = pick(pend, msk);
    end
    wr(2, 12'h000, 12'hfff);
    check("stack_ovf_o", {15'h0, stack_ovf_o}, 16'h0000);
  endtask
  task automatic rst(input int n);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    cyc(1);
    take(0);
    ret();
    check("mask", {6'h0, interrupt_mask_reg_o}, 16'h0000);
    check("pd_ack_o", {15'h0, pd_ack_o}, 16'h0000);
    check("run_o", {15'h0, run_o}, 16'h0001);
  endtask
  initial begin
    {stb, mask_data_i, control_data_i, force_data_i, clear_data_i, idle_div_i, lvl, pls} = '0;
    {idle_slow_i, osc_off_i, power_up_context_flag_i, pd_cmd} = '0;
    sp_b_irq_mode_i = 1'b1;
    sys_rst_i = 1'b1;
    seed = 19;
    rst(4);
    for (int r = 0; r < 4; r++) begin
      msk = r == 0 ? 10'h3ff : $random(seed) & 10'h3ff;
      wr(0, 12'(msk));
      pend = 12'hffe;
      wr(2, 12'hffe, 12'hfff);
      drain();
    end
    wr(0, 12'h1ff);
    wr(2, 12'h800);
    cyc(4);
    check("irq_req_o", {15'h0, irq_req_o}, 16'h0000);
    wr(0, 12'h3ff);
    cyc(3);
    wr(0, 12'h3ff);
    k = 32'(irq_req_o === 1'b0);
    cyc(1);
    k = k & 32'(irq_req_o === 1'b0);
    check("mask gap", 16'(k), 16'h0001);
    take(11);
    ret();
    wr(4);
    wr(2, 12'h800);
    @(posedge clk_i);
    pd_cmd <= 1'b1;
    cyc(5);
    check("irq_req_o", {15'h0, irq_req_o}, 16'h0000);
    @(posedge clk_i);
    pd_cmd <= 1'b0;
    wr(3);
    take(1);
    ret();
    take(11);
    ret();
    pulse(12'h040);
    take(7);
    ret();
    wr(2, 12'h080);
    wr(2, 12'h000, 12'h080);
    cyc(3);
    check("irq_req_o", {15'h0, irq_req_o}, 16'h0000);
    @(posedge clk_i);
    lvl <= 2'b10;
    take(3);
    @(posedge clk_i);
    lvl <= 2'b00;
    ret();
    cyc(4);
    check("irq_req_o", {15'h0, irq_req_o}, 16'h0000);
    wr(1, 12'h006);
    pulse(12'hc00);
    take(2);
    ret();
    take(9);
    ret();
    wr(1, 12'h000);
    pulse(12'h800);
    cyc(4);
    check("irq_req_o", {15'h0, irq_req_o}, 16'h0000);
    for (int j = 1; j >= 0; j--) begin
      wr(1, j == 1 ? 12'h008 : 12'h000);
      wr(2, 12'h800);
      take(11);
      wr(2, 12'h004);
      cyc(4);
      check("irq_req_o", {15'h0, irq_req_o}, 16'(j));
      if (j == 1) begin
        take(2);
        ret();
      end
      ret();
      if (j == 0) begin
        take(2);
        ret();
      end
    end
    for (int s = 0; s < 5; s++) begin
      @(posedge clk_i);
      idle_slow_i <= s > 0;
      idle_div_i  <= 2'(s - 1);
      wr(5);
      cyc(1);
      check("idle_o", {15'h0, idle_o}, 16'h0001);
      pend = 0;
      for (int c = 0; c < (16 << 2'(s - 1)); c++) begin
        cyc(1);
        pend += 32'(clk_en_o === 1'b1);
      end
      check("clk_en_o", 16'(pend), 16'(s > 0 ? 1 : 128));
      wr(2, 12'h800);
      k = 0;
      while (run_o !== 1'b1 && k < 300) begin
        cyc(1);
        k++;
      end
      check("wake", 16'(k <= (s > 0 ? 8 << s : 0) + 4), 16'h0001);
      take(11);
      ret();
    end
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_i);
      osc_off_i               <= 1'(s);
      power_up_context_flag_i <= 1'(s);
      wr(6);
      cyc(1);
      check("pd_ack_o", {15'h0, pd_ack_o}, 16'h0001);
      check("clk_en_o", {15'h0, clk_en_o}, 16'h0000);
      @(posedge clk_i);
      pd_cmd <= 1'b1;
      k = 0;
      while (run_o !== 1'b1 && k < 40) begin
        cyc(1);
        k++;
      end
      msk = s == 1 ? RO : RR;
      check("recovery", 16'(k >= msk + 1 && k <= msk + 3), 16'h0001);
      if (s == 1) begin
        take(0);
        ret();
      end
      @(posedge clk_i);
      pd_cmd <= 1'b0;
      rst(1);
    end
    wr(6);
    rst(1);
    results();
  end
endmodule // tb_dsp_interrupt_and_low_power_control
